// File: core/fcdi_params.svh
// Offsets, field positions, reset values and masks of the floppy configuration bank
`ifndef FCDI_PARAMS_SVH
`define FCDI_PARAMS_SVH

`define FCDI_IDX_ACTIVATE       8'h30
`define FCDI_IDX_FLOPPY_CONFIG  8'hf0
`define FCDI_IDX_DRIVE_IDENTIFICATION       8'hf1

`define FCDI_RST_ACTIVATE       8'h00
`define FCDI_RST_FLOPPY_CONFIG  8'h24
`define FCDI_RST_DRIVE_IDENTIFICATION       8'h00

`define FCDI_MASK_ACTIVATE      8'h01
`define FCDI_MASK_FLOPPY_CONFIG 8'h6d
`define FCDI_MASK_DRIVE_IDENTIFICATION      8'h0f

`define FCDI_BIT_ACTIVE         0
`define FCDI_BIT_TDR_MODE       6
`define FCDI_BIT_DENS_POL       5
`define FCDI_BIT_FORCE_WP       3
`define FCDI_BIT_DRIVE_MODE     2
`define FCDI_BIT_TRISTATE       0

`define FCDI_ID_DRV1_HI         3
`define FCDI_ID_DRV1_LO         2
`define FCDI_ID_DRV0_HI         1
`define FCDI_ID_DRV0_LO         0

`define FCDI_TDR_CLASSIC_UPPER  6'h3f
`define FCDI_RDATA_IDLE         8'h00

`endif

// File: core/fcdi_pkg.sv
// Types shared by the floppy configuration bank
package fcdi_pkg;

    typedef logic [7:0] fcdi_byte_t;
    typedef logic [1:0] fcdi_id_pair_t;

    typedef enum logic [1:0] {
        FCDI_SEL_NONE     = 2'b00,
        FCDI_SEL_ACTIVATE = 2'b01,
        FCDI_SEL_CONFIG   = 2'b10,
        FCDI_SEL_DRIVE_IDENTIFICATION = 2'b11
    } fcdi_sel_e;

endpackage : fcdi_pkg

// File: core/fcdi_cfg_if.sv
// Decoded configuration fields from the register bank to its consumers
`timescale 1ns/100ps
`default_nettype none

interface fcdi_cfg_if;
    import fcdi_pkg::*;

    logic          tdr_enhanced;
    logic          dens_pol_high;
    logic          force_wp;
    logic          classic_mode;
    logic          tristate_en;
    logic          active;
    fcdi_id_pair_t drive0_id;
    fcdi_id_pair_t drive1_id;

    modport regs (
        output tdr_enhanced, dens_pol_high, force_wp, classic_mode,
        output tristate_en, active, drive0_id, drive1_id
    );

    modport view (
        input tdr_enhanced, dens_pol_high, force_wp, classic_mode,
        input tristate_en, active, drive0_id, drive1_id
    );
endinterface : fcdi_cfg_if

`default_nettype wire

// File: core/fcdi_tdr_view.sv
// Read value of the tape drive register as shaped by the configuration
`timescale 1ns/100ps
`default_nettype none
`include "fcdi_params.svh"

module fcdi_tdr_view
    import fcdi_pkg::*;
(
    // Clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_sys_rst,
    // Configuration
    fcdi_cfg_if.view   cfg,
    // Controller core
    input  wire logic  i_drive_sel,
    input  wire logic [1:0] i_tape_sel,
    output logic [7:0] o_tdr_value
);
    fcdi_id_pair_t id_sel;
    fcdi_byte_t    tdr_next;

    always_comb begin
        id_sel = i_drive_sel ? cfg.drive1_id : cfg.drive0_id;
        if (cfg.tdr_enhanced) begin
            // Bits 7:6 and 3:2 read as zero in enhanced mode
            tdr_next = {2'b00, id_sel, 2'b00, i_tape_sel};
        end else begin
            tdr_next = {`FCDI_TDR_CLASSIC_UPPER, i_tape_sel};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_tdr_value <= {`FCDI_TDR_CLASSIC_UPPER, 2'b00};
        end else begin
            o_tdr_value <= tdr_next;
        end
    end
endmodule : fcdi_tdr_view

`default_nettype wire

// File: core/fcdi_pin_ctrl.sv
// Drive pin shaping: density polarity, write protection, output float
`timescale 1ns/100ps
`default_nettype none
`include "fcdi_params.svh"

module fcdi_pin_ctrl
    import fcdi_pkg::*;
(
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    // Configuration
    fcdi_cfg_if.view  cfg,
    // Controller core
    input  wire logic i_high_rate,
    input  wire logic i_write_gate_req,
    input  wire logic i_write_protect_n,
    output logic      o_write_protect,
    output logic      o_classic_drive_mode,
    // Drive pins
    output logic      o_density_select_output_out,
    output logic      o_density_select_output_oe,
    output logic      o_write_gate_n_out,
    output logic      o_write_gate_n_oe
);
    logic protect;
    logic float_pins;

    assign protect    = cfg.force_wp | ~i_write_protect_n;
    assign float_pins = cfg.tristate_en & ~cfg.active;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_write_protect             <= 1'b0;
            o_classic_drive_mode        <= 1'b1;
            o_density_select_output_out <= 1'b0;
            o_write_gate_n_out          <= 1'b1;
        end else begin
            o_write_protect             <= protect;
            o_classic_drive_mode        <= cfg.classic_mode;
            o_density_select_output_out <= cfg.dens_pol_high ? i_high_rate : ~i_high_rate;
            // Protection wins over any gate request from the core
            o_write_gate_n_out          <= ~(i_write_gate_req & ~protect);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_density_select_output_oe <= 1'b1;
            o_write_gate_n_oe          <= 1'b1;
        end else begin
            o_density_select_output_oe <= ~float_pins;
            o_write_gate_n_oe          <= ~float_pins;
        end
    end
endmodule : fcdi_pin_ctrl

`default_nettype wire

// File: core/fcdi_top.sv
// Floppy controller configuration and drive identification register bank
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "fcdi_params.svh"

module fcdi_top
    import fcdi_pkg::*;
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Controller core
    input  wire logic       i_drive_sel,
    input  wire logic [1:0] i_tape_sel,
    input  wire logic       i_high_rate,
    input  wire logic       i_write_gate_req,
    output logic      [7:0] o_tdr_value,
    output logic            o_write_protect,
    output logic            o_classic_drive_mode,
    // Drive pins
    input  wire logic       i_write_protect_n,
    output logic            o_density_select_output_out,
    output logic            o_density_select_output_oe,
    output logic            o_write_gate_n_out,
    output logic            o_write_gate_n_oe
);
    function automatic fcdi_sel_e fcdi_decode(input fcdi_byte_t addr);
        if (addr == `FCDI_IDX_ACTIVATE) begin
            fcdi_decode = FCDI_SEL_ACTIVATE;
        end else if (addr == `FCDI_IDX_FLOPPY_CONFIG) begin
            fcdi_decode = FCDI_SEL_CONFIG;
        end else if (addr == `FCDI_IDX_DRIVE_IDENTIFICATION) begin
            fcdi_decode = FCDI_SEL_DRIVE_IDENTIFICATION;
        end else begin
            fcdi_decode = FCDI_SEL_NONE;
        end
    endfunction : fcdi_decode

    fcdi_byte_t activate_reg;
    fcdi_byte_t floppy_config_reg;
    fcdi_byte_t drive_identification_reg;
    fcdi_byte_t rdata_next;
    fcdi_sel_e  wr_sel;
    fcdi_sel_e  rd_sel;

    fcdi_cfg_if cfg ();

    assign wr_sel = fcdi_decode(i_addr);
    assign rd_sel = fcdi_decode(i_addr);

    // Reserved bits are masked at the write so they can never steer anything
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            activate_reg <= `FCDI_RST_ACTIVATE;
        end else if (i_wr && wr_sel == FCDI_SEL_ACTIVATE) begin
            activate_reg <= i_wdata & `FCDI_MASK_ACTIVATE;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            floppy_config_reg <= `FCDI_RST_FLOPPY_CONFIG;
        end else if (i_wr && wr_sel == FCDI_SEL_CONFIG) begin
            floppy_config_reg <= i_wdata & `FCDI_MASK_FLOPPY_CONFIG;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            drive_identification_reg <= `FCDI_RST_DRIVE_IDENTIFICATION;
        end else if (i_wr && wr_sel == FCDI_SEL_DRIVE_IDENTIFICATION) begin
            drive_identification_reg <= i_wdata & `FCDI_MASK_DRIVE_IDENTIFICATION;
        end
    end

    always_comb begin
        rdata_next = `FCDI_RDATA_IDLE;
        if (i_rd) begin
            if (rd_sel == FCDI_SEL_ACTIVATE) begin
                rdata_next = activate_reg;
            end else if (rd_sel == FCDI_SEL_CONFIG) begin
                rdata_next = floppy_config_reg;
            end else if (rd_sel == FCDI_SEL_DRIVE_IDENTIFICATION) begin
                rdata_next = drive_identification_reg;
            end
        end
    end

    // Read data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rdata <= `FCDI_RDATA_IDLE;
        end else begin
            o_rdata <= rdata_next;
        end
    end

    assign cfg.active        = activate_reg[`FCDI_BIT_ACTIVE];
    assign cfg.tdr_enhanced  = floppy_config_reg[`FCDI_BIT_TDR_MODE];
    assign cfg.dens_pol_high = floppy_config_reg[`FCDI_BIT_DENS_POL];
    assign cfg.force_wp      = floppy_config_reg[`FCDI_BIT_FORCE_WP];
    assign cfg.classic_mode  = floppy_config_reg[`FCDI_BIT_DRIVE_MODE];
    assign cfg.tristate_en   = floppy_config_reg[`FCDI_BIT_TRISTATE];
    assign cfg.drive1_id     = drive_identification_reg[`FCDI_ID_DRV1_HI:`FCDI_ID_DRV1_LO];
    assign cfg.drive0_id     = drive_identification_reg[`FCDI_ID_DRV0_HI:`FCDI_ID_DRV0_LO];

    fcdi_tdr_view fcdi_tdr_view_i (
        .i_core_clk  (i_core_clk),
        .i_sys_rst   (i_sys_rst),
        .cfg         (cfg.view),
        .i_drive_sel (i_drive_sel),
        .i_tape_sel  (i_tape_sel),
        .o_tdr_value (o_tdr_value)
    );

    fcdi_pin_ctrl fcdi_pin_ctrl_i (
        .i_core_clk                  (i_core_clk),
        .i_sys_rst                   (i_sys_rst),
        .cfg                         (cfg.view),
        .i_high_rate                 (i_high_rate),
        .i_write_gate_req            (i_write_gate_req),
        .i_write_protect_n           (i_write_protect_n),
        .o_write_protect             (o_write_protect),
        .o_classic_drive_mode        (o_classic_drive_mode),
        .o_density_select_output_out (o_density_select_output_out),
        .o_density_select_output_oe  (o_density_select_output_oe),
        .o_write_gate_n_out          (o_write_gate_n_out),
        .o_write_gate_n_oe           (o_write_gate_n_oe)
    );
endmodule : fcdi_top

`default_nettype wire

// File: verif/fcdi_properties.sv
// Port-level checks of the floppy configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "fcdi_params.svh"
module fcdi_properties (
    input wire logic       i_core_clk,
    input wire logic       i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_drive_sel,
    input wire logic [1:0] i_tape_sel,
    input wire logic       i_high_rate,
    input wire logic       i_write_gate_req,
    input wire logic [7:0] o_tdr_value,
    input wire logic       o_write_protect,
    input wire logic       o_classic_drive_mode,
    input wire logic       i_write_protect_n,
    input wire logic       o_density_select_output_out,
    input wire logic       o_density_select_output_oe,
    input wire logic       o_write_gate_n_out,
    input wire logic       o_write_gate_n_oe
);
    logic [7:0] cfg_reg;
    logic [7:0] id_reg;
    logic       act_reg;
    logic [1:0] id_sel;
    // Shadow bank, masked the way the design stores it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cfg_reg <= `FCDI_RST_FLOPPY_CONFIG;
            id_reg  <= `FCDI_RST_DRIVE_IDENTIFICATION;
            act_reg <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == `FCDI_IDX_FLOPPY_CONFIG) cfg_reg <= i_wdata & `FCDI_MASK_FLOPPY_CONFIG;
            if (i_addr == `FCDI_IDX_DRIVE_IDENTIFICATION) id_reg <= i_wdata & `FCDI_MASK_DRIVE_IDENTIFICATION;
            if (i_addr == `FCDI_IDX_ACTIVATE) act_reg <= i_wdata[0];
        end
    end
    assign id_sel = i_drive_sel ? id_reg[3:2] : id_reg[1:0];
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    chk_rdata_cfg: assert property ($past(i_rd) && $past(i_addr) == 8'hf0 |-> o_rdata == $past(cfg_reg))
        else $error("config read data wrong");
    chk_rdata_id: assert property ($past(i_rd) && $past(i_addr) == 8'hf1 |-> o_rdata == $past(id_reg))
        else $error("drive_identification read data wrong");
    chk_tdr_classic: assert property (!$past(i_sys_rst) && !$past(cfg_reg[6])
        |-> o_tdr_value == {6'h3f, $past(i_tape_sel)})
        else $error("classic tape value wrong");
    chk_tdr_enh_id: assert property (!$past(i_sys_rst) && $past(cfg_reg[6])
        |-> o_tdr_value == {2'b00, $past(id_sel), 2'b00, $past(i_tape_sel)})
        else $error("enhanced tape value wrong");
    chk_density_pol: assert property (!$past(i_sys_rst)
        |-> o_density_select_output_out == ($past(i_high_rate) ^ !$past(cfg_reg[5])))
        else $error("density polarity wrong");
    chk_protect_force: assert property (!$past(i_sys_rst)
        |-> o_write_protect == ($past(cfg_reg[3]) | !$past(i_write_protect_n)))
        else $error("write protect wrong");
    chk_gate_blocked: assert property (!$past(i_sys_rst)
        |-> o_write_gate_n_out == !($past(i_write_gate_req) && !$past(cfg_reg[3]) && $past(i_write_protect_n)))
        else $error("write gate not blocked");
    chk_drive_mode: assert property (!$past(i_sys_rst) |-> o_classic_drive_mode == $past(cfg_reg[2]))
        else $error("drive mode wrong");
    chk_float_oe: assert property (!$past(i_sys_rst) |-> o_write_gate_n_oe == o_density_select_output_oe
        && o_density_select_output_oe == !($past(cfg_reg[0]) && !$past(act_reg)))
        else $error("output float wrong");
endmodule : fcdi_properties
bind fcdi_top fcdi_properties fcdi_properties_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_drive_sel(i_drive_sel),
    .i_tape_sel(i_tape_sel), .i_high_rate(i_high_rate), .i_write_gate_req(i_write_gate_req),
    .o_tdr_value(o_tdr_value), .o_write_protect(o_write_protect), .o_classic_drive_mode(o_classic_drive_mode),
    .i_write_protect_n(i_write_protect_n), .o_density_select_output_out(o_density_select_output_out),
    .o_density_select_output_oe(o_density_select_output_oe), .o_write_gate_n_out(o_write_gate_n_out),
    .o_write_gate_n_oe(o_write_gate_n_oe));
`default_nettype wire

// File: verif/fcdi_core_model.sv
// Controller core and drive pins: fixed levels or a pattern changing every cycle
`timescale 1ns/100ps
`default_nettype none
module fcdi_core_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_run,
    input  wire logic [5:0] i_fix,
    output logic            o_drive_sel,
    output logic      [1:0] o_tape_sel,
    output logic            o_high_rate,
    output logic            o_write_gate_req,
    output logic            o_write_protect_n
);
    logic [5:0] cnt_reg = 6'h00;
    // Odd step so every bit pattern comes round
    always_ff @(posedge i_core_clk) begin
        if (i_run) cnt_reg <= cnt_reg + 6'h05;
    end
    assign {o_write_protect_n, o_write_gate_req, o_high_rate, o_tape_sel, o_drive_sel} = i_run ? cnt_reg : i_fix;
endmodule : fcdi_core_model
`default_nettype wire

// File: verif/fcdi_top_tb.sv
// Self-checking bench of the floppy configuration bank
`timescale 1ns/100ps
`default_nettype none
module fcdi_top_tb;
    import fcdi_pkg::*;
    logic i_core_clk, i_sys_rst, i_wr, i_rd, i_run, ds, hr, wgr, wpn;
    logic dso, dsoe, wgo, wgoe, wp, cdm;
    logic [1:0] ts;
    logic [5:0] i_fix;
    fcdi_byte_t i_addr, i_wdata, o_rdata, o_tdr_value;
    int failures, checked;
    fcdi_top fcdi_top_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_drive_sel(ds), .i_tape_sel(ts), .i_high_rate(hr),
        .i_write_gate_req(wgr), .o_tdr_value(o_tdr_value), .o_write_protect(wp), .o_classic_drive_mode(cdm),
        .i_write_protect_n(wpn), .o_density_select_output_out(dso), .o_density_select_output_oe(dsoe),
        .o_write_gate_n_out(wgo), .o_write_gate_n_oe(wgoe));
    fcdi_core_model fcdi_core_model_i (.i_core_clk(i_core_clk), .i_run(i_run), .i_fix(i_fix), .o_drive_sel(ds),
        .o_tape_sel(ts), .o_high_rate(hr), .o_write_gate_req(wgr), .o_write_protect_n(wpn));
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    task complete_run;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task compare(input fcdi_byte_t got, input fcdi_byte_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask : compare
    task reg_wr(input fcdi_byte_t a, input fcdi_byte_t d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : reg_wr
    task reg_rd(input fcdi_byte_t a, input fcdi_byte_t exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        compare(o_rdata, exp);
    endtask : reg_rd
    // Fields: write protect n, write request, high rate, tape select, drive select
    task pins(input logic [5:0] f);
        @(posedge i_core_clk);
        i_fix <= f;
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask : pins
    task test_reset;
        reg_rd(8'h30, 8'h00);
        reg_rd(8'hf0, 8'h24);
        reg_rd(8'hf1, 8'h00);
        compare(8'(cdm), 8'h01);
        $display("test reset done");
    endtask : test_reset
    task test_reserved;
        reg_wr(8'hf0, 8'h6f);
        reg_rd(8'hf0, 8'h6d);
        reg_wr(8'hf1, 8'hff);
        reg_rd(8'hf1, 8'h0f);
        reg_wr(8'h30, 8'hff);
        reg_rd(8'h30, 8'h01);
        reg_wr(8'h55, 8'hff);
        reg_rd(8'h55, 8'h00);
        reg_wr(8'hf0, 8'h24);
        reg_wr(8'hf1, 8'h0b);
        reg_wr(8'h30, 8'h00);
        $display("test reserved done");
    endtask : test_reserved
    task test_tdr;
        pins(6'b000100);
        compare(o_tdr_value, 8'hfe);
        reg_wr(8'hf0, 8'h64);
        pins(6'b000100);
        compare(o_tdr_value, 8'h32);
        pins(6'b000101);
        compare(o_tdr_value, 8'h22);
        reg_wr(8'hf0, 8'h24);
        pins(6'b000101);
        compare(o_tdr_value, 8'hfe);
        $display("test tdr done");
    endtask : test_tdr
    task test_pins;
        pins(6'b111000);
        compare({6'h00, dso, wgo}, 8'h02);
        reg_wr(8'hf0, 8'h08);
        pins(6'b111000);
        compare({5'h00, dso, wp, wgo}, 8'h03);
        compare(8'(cdm), 8'h00);
        reg_wr(8'hf0, 8'h25);
        pins(6'b011000);
        compare({4'h0, wp, dsoe, wgoe, wgo}, 8'h09);
        reg_wr(8'h30, 8'h01);
        pins(6'b011000);
        compare({6'h00, dsoe, wgoe}, 8'h03);
        reg_wr(8'h30, 8'h00);
        reg_wr(8'hf0, 8'h24);
        $display("test pins done");
    endtask : test_pins
    task test_churn;
        reg_wr(8'hf0, 8'h64);
        i_run <= 1'b1;
        repeat (64) @(posedge i_core_clk);
        reg_rd(8'hf1, 8'h0b);
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        i_run <= 1'b0;
        reg_rd(8'hf0, 8'h24);
        $display("test churn done");
    endtask : test_churn
    initial begin
        repeat (20000) @(posedge i_core_clk);
        failures++;
        $display("MISMATCH %0t run did not end", $time);
        complete_run();
    end
    initial begin
        {i_sys_rst, i_wr, i_rd, i_run, i_addr, i_wdata, i_fix} = {1'b1, 25'h0};
        repeat (20) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        #1;
        compare(o_tdr_value, 8'hfc);
        test_reset();
        test_reserved();
        test_tdr();
        test_pins();
        test_churn();
        complete_run();
    end
endmodule : fcdi_top_tb
`default_nettype wire
